// >>> verilog/pfm_defines.vh
`ifndef PFM_DEFINES_VH
`define PFM_DEFINES_VH

// Register offsets (byte addresses on the plain port)
`define PFM_ADDR_LIM_1_0     8'h60
`define PFM_ADDR_LIM_3_2     8'h61
`define PFM_ADDR_LIM_5_4     8'h62
`define PFM_ADDR_LIM_7_6     8'h63
`define PFM_ADDR_LIM_9_8     8'h64
`define PFM_ADDR_LIM_10      8'h65
`define PFM_ADDR_FAIL_7_0    8'h66
`define PFM_ADDR_FAIL_10_8   8'h67
`define PFM_ADDR_IRQ_STAT_LO 8'h40
`define PFM_ADDR_IRQ_STAT_HI 8'h41
`define PFM_ADDR_IRQ_MASK_LO 8'h42
`define PFM_ADDR_IRQ_MASK_HI 8'h43

// Reset values
`define PFM_RST_LIM_PAIR     8'h33
`define PFM_RST_LIM_SINGLE   8'h03
`define PFM_RST_MASK         11'h000

// Field positions
`define PFM_ODD_LSB          4
`define PFM_EVEN_LSB         0
`define PFM_PAIR_MASK        8'h77
`define PFM_SINGLE_MASK      8'h07

// Number of references
`define PFM_NUM_REF          11

// Thresholds in units of 0.1 ppm, 12-bit
`define PFM_ACC_0            12'h05C
`define PFM_REJ_0            12'h078
`define PFM_ACC_1            12'h190
`define PFM_REJ_1            12'h208
`define PFM_ACC_2            12'h280
`define PFM_REJ_2            12'h33E
`define PFM_ACC_3            12'h3E8
`define PFM_REJ_3            12'h514
`define PFM_ACC_4            12'h08A
`define PFM_REJ_4            12'h0B4
`define PFM_ACC_5            12'h0F6
`define PFM_REJ_5            12'h140
`define PFM_ACC_6            12'h16E
`define PFM_REJ_6            12'h1DB
`define PFM_ACC_7            12'h208
`define PFM_REJ_7            12'h2A3

`endif

// >>> verilog/pfm_ref_judge.v
`timescale 1ns/100ps
`include "pfm_defines.vh"

module pfm_ref_judge (
    input  wire        clk_sys_in,
    input  wire        rst_n_in,
    input  wire [2:0]  limit_sel_in,
    input  wire [11:0] err_mag_in,
    input  wire        err_valid_in,
    output wire        reject_out
);

    reg [11:0] acc_thr;
    reg [11:0] rej_thr;
    reg        nxt_reject;
    reg        reject_ff;

    // ************************************
    // Threshold lookup
    // ************************************
    // code selects pair
    always @* begin
        case (limit_sel_in)
            3'h0: begin acc_thr = `PFM_ACC_0; rej_thr = `PFM_REJ_0; end
            3'h1: begin acc_thr = `PFM_ACC_1; rej_thr = `PFM_REJ_1; end
            3'h2: begin acc_thr = `PFM_ACC_2; rej_thr = `PFM_REJ_2; end
            3'h3: begin acc_thr = `PFM_ACC_3; rej_thr = `PFM_REJ_3; end
            3'h4: begin acc_thr = `PFM_ACC_4; rej_thr = `PFM_REJ_4; end
            3'h5: begin acc_thr = `PFM_ACC_5; rej_thr = `PFM_REJ_5; end
            3'h6: begin acc_thr = `PFM_ACC_6; rej_thr = `PFM_REJ_6; end
            default: begin acc_thr = `PFM_ACC_7; rej_thr = `PFM_REJ_7; end
        endcase
    end

    // ************************************
    // Decision with hysteresis
    // ************************************
    always @* begin
        nxt_reject = reject_ff;
        if (err_valid_in) begin
            if (err_mag_in > rej_thr) begin
                nxt_reject = 1'b1;
            end else if (err_mag_in < acc_thr) begin
                nxt_reject = 1'b0;
            end
        end
    end

    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reject_ff <= 1'b0;
        end else begin
            reject_ff <= nxt_reject;
        end
    end

    assign reject_out = reject_ff;

endmodule // pfm_ref_judge

// >>> verilog/pfm_limits_top.v
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`include "pfm_defines.vh"

module pfm_limits_top (
    input  wire        clk_sys_in,
    input  wire        rst_n_in,
    input  wire [7:0]  addr_in,
    input  wire [7:0]  wdata_in,
    input  wire        wr_in,
    input  wire        rd_in,
    output wire [7:0]  rdata_out,
    input  wire [131:0] err_mag_in,
    input  wire [10:0] err_valid_in,
    output wire [10:0] fail_out,
    output wire        irq_out
);

    reg  [7:0]  lim_ff [0:5];
    reg  [10:0] stat_ff;
    reg  [10:0] mask_ff;
    reg  [10:0] fail_d_ff;
    reg  [7:0]  nxt_rdata;
    reg  [7:0]  rdata_ff;
    reg  [10:0] nxt_stat;
    reg  [10:0] clr_bits;
    wire [10:0] reject;
    wire [10:0] rise;
    integer     i;

    // ************************************
    // Limit registers
    // ************************************
    // field packing and write
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (i = 0; i < 5; i = i + 1) begin
                lim_ff[i] <= `PFM_RST_LIM_PAIR;
            end
            lim_ff[5] <= `PFM_RST_LIM_SINGLE;
        end else if (wr_in) begin
            for (i = 0; i < 5; i = i + 1) begin
                if (addr_in == `PFM_ADDR_LIM_1_0 + i[7:0]) begin
                    lim_ff[i] <= wdata_in & `PFM_PAIR_MASK;
                end
            end
            if (addr_in == `PFM_ADDR_LIM_10) begin
                lim_ff[5] <= wdata_in & `PFM_SINGLE_MASK;
            end
        end
    end

    // ************************************
    // Per-input judges
    // ************************************
    // error measured upstream
    genvar g;
    generate
        for (g = 0; g < `PFM_NUM_REF; g = g + 1) begin : g_ref
            pfm_ref_judge u_judge (
                .clk_sys_in   (clk_sys_in),
                .rst_n_in     (rst_n_in),
                .limit_sel_in (lim_ff[g / 2][(g % 2) * 4 +: 3]),
                .err_mag_in   (err_mag_in[g * 12 +: 12]),
                .err_valid_in (err_valid_in[g]),
                .reject_out   (reject[g])
            );
        end
    endgenerate

    assign fail_out = reject;

    // ************************************
    // Interrupt status and mask
    // ************************************
    assign rise = reject & ~fail_d_ff;

    always @* begin
        clr_bits = 11'h000;
        if (wr_in && addr_in == `PFM_ADDR_IRQ_STAT_LO) begin
            clr_bits[7:0] = wdata_in;
        end
        if (wr_in && addr_in == `PFM_ADDR_IRQ_STAT_HI) begin
            clr_bits[10:8] = wdata_in[2:0];
        end
        nxt_stat = (stat_ff & ~clr_bits) | rise;
    end

    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stat_ff   <= 11'h000;
            mask_ff   <= `PFM_RST_MASK;
            fail_d_ff <= 11'h000;
        end else begin
            stat_ff   <= nxt_stat;
            fail_d_ff <= reject;
            if (wr_in && addr_in == `PFM_ADDR_IRQ_MASK_LO) begin
                mask_ff[7:0] <= wdata_in;
            end
            if (wr_in && addr_in == `PFM_ADDR_IRQ_MASK_HI) begin
                mask_ff[10:8] <= wdata_in[2:0];
            end
        end
    end

    assign irq_out = |(stat_ff & mask_ff);

    // ************************************
    // Read mux
    // ************************************
    always @* begin
        case (addr_in)
            `PFM_ADDR_LIM_1_0:     nxt_rdata = lim_ff[0];
            `PFM_ADDR_LIM_3_2:     nxt_rdata = lim_ff[1];
            `PFM_ADDR_LIM_5_4:     nxt_rdata = lim_ff[2];
            `PFM_ADDR_LIM_7_6:     nxt_rdata = lim_ff[3];
            `PFM_ADDR_LIM_9_8:     nxt_rdata = lim_ff[4];
            `PFM_ADDR_LIM_10:      nxt_rdata = lim_ff[5];
            `PFM_ADDR_FAIL_7_0:    nxt_rdata = reject[7:0];
            `PFM_ADDR_FAIL_10_8:   nxt_rdata = {5'h00, reject[10:8]};
            `PFM_ADDR_IRQ_STAT_LO: nxt_rdata = stat_ff[7:0];
            `PFM_ADDR_IRQ_STAT_HI: nxt_rdata = {5'h00, stat_ff[10:8]};
            `PFM_ADDR_IRQ_MASK_LO: nxt_rdata = mask_ff[7:0];
            `PFM_ADDR_IRQ_MASK_HI: nxt_rdata = {5'h00, mask_ff[10:8]};
            default:               nxt_rdata = 8'h00;
        endcase
    end

    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_ff <= 8'h00;
        end else if (rd_in) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign rdata_out = rdata_ff;

endmodule // pfm_limits_top

// >>> tb/pfm_limits_properties.sv
`timescale 1ns/100ps
// ****
// Checker
// ****
module pfm_limits_props (
    input wire         clk_sys_in,
    input wire         rst_n_in,
    input wire [7:0]   addr_in,
    input wire         wr_in,
    input wire         rd_in,
    input wire [7:0]   rdata_out,
    input wire [131:0] err_mag_in,
    input wire [10:0]  err_valid_in,
    input wire [10:0]  fail_out,
    input wire         irq_out
);
    reg  [10:0] prev_fail_ff;
    wire        rise_any = |(fail_out & ~prev_fail_ff);
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in)
            prev_fail_ff <= 11'h000;
        else
            prev_fail_ff <= fail_out;
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_rd(a);
        rd_in && addr_in == a;
    endsequence
    a_rdata_idle: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("read data not zero");
    a_fail_lo: assert property (s_rd(8'h66) |=> rdata_out == $past(fail_out[7:0]))
        else $error("failure status low wrong");
    a_fail_hi: assert property (s_rd(8'h67) |=> rdata_out == {5'h00, $past(fail_out[10:8])})
        else $error("failure status high wrong");
    a_reserved_zero: assert property (rd_in && addr_in >= 8'h60 && addr_in <= 8'h65
        |=> !rdata_out[7] && !rdata_out[3])
        else $error("reserved bit read one");
    a_max_reject: assert property (err_valid_in[0] && err_mag_in[11:0] > 12'h514 |=> fail_out[0])
        else $error("large error not rejected");
    a_min_accept: assert property (err_valid_in[0] && err_mag_in[11:0] < 12'h05C |=> !fail_out[0])
        else $error("small error not accepted");
    a_hold_idle: assert property (!err_valid_in[0] |=> $stable(fail_out[0]))
        else $error("state moved without sample");
    a_own_input: assert property (!err_valid_in[1] |=> $stable(fail_out[1]))
        else $error("input one moved by other input");
    a_irq_cause: assert property ($rose(irq_out) |-> ($past(wr_in) || $past(rise_any)))
        else $error("interrupt without cause");
endmodule // pfm_limits_props

bind pfm_limits_top pfm_limits_props u_props (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .err_mag_in(err_mag_in), .err_valid_in(err_valid_in), .fail_out(fail_out),
    .irq_out(irq_out));

// >>> tb/pfm_limits_tb_top.sv
`timescale 1ns/100ps
`include "pfm_defines.vh"
// ****
// Bench
// ****
module pfm_limits_tb_top;
    localparam [95:0] ACC = {`PFM_ACC_7, `PFM_ACC_6, `PFM_ACC_5, `PFM_ACC_4,
                             `PFM_ACC_3, `PFM_ACC_2, `PFM_ACC_1, `PFM_ACC_0};
    localparam [95:0] REJ = {`PFM_REJ_7, `PFM_REJ_6, `PFM_REJ_5, `PFM_REJ_4,
                             `PFM_REJ_3, `PFM_REJ_2, `PFM_REJ_1, `PFM_REJ_0};
    reg         clk_sys_in   = 1'b0;
    reg         rst_n_in     = 1'b0;
    reg [7:0]   addr_in      = 8'h00;
    reg [7:0]   wdata_in     = 8'h00;
    reg         wr_in        = 1'b0;
    reg         rd_in        = 1'b0;
    reg [131:0] err_mag_in   = 132'h0;
    reg [10:0]  err_valid_in = 11'h000;
    wire [7:0]  rdata_out;
    wire [10:0] fail_out;
    wire        irq_out;
    integer     mismatches   = 0;
    integer     n_compared   = 0;
    reg [7:0]   k;
    always #12.5 clk_sys_in = ~clk_sys_in;
    pfm_limits_top dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .err_mag_in(err_mag_in), .err_valid_in(err_valid_in), .fail_out(fail_out),
        .irq_out(irq_out));
    task cmp(input string what, input [10:0] exp, input [10:0] got);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("BAD %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk_sys_in);
            wr_in <= 1'b1;
            addr_in <= a;
            wdata_in <= d;
            @(posedge clk_sys_in);
            wr_in <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [7:0] e);
        begin
            @(posedge clk_sys_in);
            rd_in <= 1'b1;
            addr_in <= a;
            @(posedge clk_sys_in);
            rd_in <= 1'b0;
            #1 cmp("rdata", {3'b000, e}, {3'b000, rdata_out});
        end
    endtask
    task judge(input [7:0] g, input [11:0] e, input x);
        begin
            @(posedge clk_sys_in);
            err_mag_in[g*12 +: 12] <= e;
            err_valid_in <= 11'h001 << g;
            @(posedge clk_sys_in);
            err_valid_in <= 11'h000;
            #1 cmp("fail", x ? (11'h001 << g) : 11'h000, fail_out);
        end
    endtask
    task give_verdict;
        begin
            $display("compared %0d mismatches %0d", n_compared, mismatches);
            if (mismatches == 0 && n_compared > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    initial begin
        repeat (2) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        for (k = 8'h00; k < 8'h06; k = k + 8'h01)
            rd(8'h60 + k, (k == 8'h05) ? 8'h03 : 8'h33);
        wr(8'h60, 8'hFF);
        rd(8'h60, 8'h77);
        wr(8'h65, 8'hFF);
        rd(8'h65, 8'h07);
        rd(8'h7F, 8'h00);
        wr(8'h42, 8'h01);
        for (k = 8'h00; k < 8'h0B; k = k + 8'h01) begin
            wr(8'h60 + {1'b0, k[7:1]}, k[0] ? {1'b0, k[2:0], 4'h0} : {5'h00, k[2:0]});
            judge(k, REJ[k[2:0]*12 +: 12] + 12'h001, 1'b1);
            rd(8'h66 + {7'h00, k[3]}, 8'h01 << k[2:0]);
            judge(k, ACC[k[2:0]*12 +: 12], 1'b1);
            judge(k, ACC[k[2:0]*12 +: 12] - 12'h001, 1'b0);
            judge(k, REJ[k[2:0]*12 +: 12], 1'b0);
        end
        rd(8'h40, 8'hFF);
        rd(8'h41, 8'h07);
        cmp("irq", 11'h001, {10'h000, irq_out});
        wr(8'h40, 8'h01);
        rd(8'h40, 8'hFE);
        cmp("irq", 11'h000, {10'h000, irq_out});
        wr(8'h42, 8'h02);
        rd(8'h42, 8'h02);
        cmp("irq", 11'h001, {10'h000, irq_out});
        wr(8'h40, 8'hFE);
        wr(8'h41, 8'h07);
        rd(8'h40, 8'h00);
        cmp("irq", 11'h000, {10'h000, irq_out});
        wr(8'h43, 8'hFF);
        rd(8'h43, 8'h07);
        cmp("irq", 11'h000, {10'h000, irq_out});
        // Large error and status clear in the same cycle: set wins
        @(posedge clk_sys_in);
        err_mag_in[11:0] <= 12'hFFF;
        err_valid_in <= 11'h001;
        @(posedge clk_sys_in);
        err_valid_in <= 11'h000;
        wr_in <= 1'b1;
        addr_in <= 8'h40;
        wdata_in <= 8'h01;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
        #1 cmp("fail", 11'h001, fail_out);
        rd(8'h40, 8'h01);
        // Reset in mid-run restores defaults
        @(posedge clk_sys_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        #1 cmp("fail", 11'h000, fail_out);
        rd(8'h40, 8'h00);
        rd(8'h43, 8'h00);
        rd(8'h61, 8'h33);
        judge(8'h00, `PFM_REJ_3, 1'b0);
        judge(8'h00, `PFM_REJ_3 + 12'h001, 1'b1);
        give_verdict;
    end
endmodule // pfm_limits_tb_top
